// ### pmc_pkg.sv
// Purpose: shared constants and types for the power mode controller
// Assumes: 125 MHz system clock
// Notes: exit delays give deep sleep > low power idle > system idle
package pmc_pkg;

  // ***************************************************
  // modes and sequencer states
  // ***************************************************
  typedef enum logic [2:0] {
    PMC_M_OFF,
    PMC_M_BATT,
    PMC_M_RET,
    PMC_M_DSLEEP,
    PMC_M_LPIDLE,
    PMC_M_SIDLE,
    PMC_M_RUN
  } pmc_mode_type;

  typedef enum logic [1:0] {
    PMC_S_STEADY,
    PMC_S_RAILS,
    PMC_S_CLOCKS
  } pmc_seq_type;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_MHZ = 125;
  localparam int EXIT_DSLEEP_US = 40;
  localparam int EXIT_LPIDLE_US = 10;
  localparam int EXIT_SIDLE_US = 1;
  localparam logic [15:0] EXIT_DSLEEP_CYC = 16'(EXIT_DSLEEP_US * CLK_MHZ);
  localparam logic [15:0] EXIT_LPIDLE_CYC = 16'(EXIT_LPIDLE_US * CLK_MHZ);
  localparam logic [15:0] EXIT_SIDLE_CYC = 16'(EXIT_SIDLE_US * CLK_MHZ);
  localparam logic [15:0] EXIT_RET_CYC = 16'(EXIT_DSLEEP_US * CLK_MHZ);
  localparam logic [15:0] CLK_STEP_CYC = 16'h0004;
  // cycles without activity before auto system idle
  localparam logic [15:0] IDLE_AUTO_CYC = 16'h0100;

  // ***************************************************
  // widths and reset values
  // ***************************************************
  localparam int RET_IO_N = 16;
  localparam int RET_IO_WDOG = 0;
  localparam int PERI_N = 8;
  localparam logic [PERI_N-1:0] PERI_CLK_RST = 8'h00;
endpackage

// ### pmc_sync.sv
// Purpose: two flip-flop synchroniser for a bus of async levels
// Assumes: inputs are quasi-static levels
// Notes: first stage is read only by the second
`timescale 1ns/100ps
module pmc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_ff;

  // two stages, reset to zero
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      meta_ff <= '0;
      sync_o <= '0;
    end else begin
      meta_ff <= async_i;
      sync_o <= meta_ff;
    end
  end
endmodule

// ### pmc_power_mode_controller.sv
// Purpose: power mode sequencer driving rails, DRAM retention and clocks
// Assumes: wake pins and wait-for-interrupt come from outside, synchronised here
// Notes: mode requests are one-cycle pulses from software logic
`timescale 1ns/100ps
module pmc_power_mode_controller (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // software control
  input wire logic req_i,
  input wire pmc_pkg::pmc_mode_type req_mode_i,
  input wire logic dram_off_sel_i,
  input wire logic phy_en_i,
  input wire logic [pmc_pkg::PERI_N-1:0] peri_keep_i,
  input wire logic auto_idle_en_i,
  input wire logic low_vcore_i,
  input wire logic freq_low_i,
  // system activity and wake sources (asynchronous)
  input wire logic activity_i,
  input wire logic wait_for_interrupt_state_i,
  input wire logic wake_i,
  input wire logic [pmc_pkg::RET_IO_N-1:0] retention_io_pins_i,
  input wire logic [pmc_pkg::RET_IO_N-1:0] ret_out_i,
  // rails
  output logic vbat_en_o,
  output logic vin_en_o,
  output logic ret_io_en_o,
  output logic dram_rail_en_o,
  output logic soc_en_o,
  output logic cpu_en_o,
  output logic phy_en_o,
  output logic peripheral_power_enable_o,
  output logic vcore_low_o,
  // dram, cpu and clocks
  output logic dram_retention_pin_o,
  output logic dram_self_refresh_o,
  output logic cpu_run_o,
  output logic cpu_clk_en_o,
  output logic sys_clk_en_o,
  output logic slow_clk_en_o,
  output logic [pmc_pkg::PERI_N-1:0] peri_clk_en_o,
  // retention io outputs and status
  output logic [pmc_pkg::RET_IO_N-1:0] retention_io_pins_o,
  output pmc_pkg::pmc_mode_type mode_o,
  output logic busy_o
);

  // ***************************************************
  // input synchronisers
  // ***************************************************
  localparam int SW = pmc_pkg::RET_IO_N + 3;
  logic [SW-1:0] sync_in;
  logic activity_s, wfi_s, wake_s;
  logic [pmc_pkg::RET_IO_N-1:0] rio_s;
  pmc_sync #(.W(SW)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({activity_i, wait_for_interrupt_state_i, wake_i, retention_io_pins_i}),
    .sync_o(sync_in)
  );
  assign {activity_s, wfi_s, wake_s, rio_s} = sync_in;

  // ***************************************************
  // sequencer
  // ***************************************************
  pmc_pkg::pmc_mode_type mode_ff;
  pmc_pkg::pmc_seq_type seq_ff;
  logic [15:0] cnt_ff;
  logic [15:0] idle_cnt_ff;
  logic [pmc_pkg::RET_IO_N-1:0] rio_prev_ff;
  logic [pmc_pkg::PERI_N-1:0] peri_keep_ff;
  logic rio_event, low_power, auto_idle;
  // any edge on a retention pin counts as a wake event, in retention mode only
  assign rio_event = |(rio_s ^ rio_prev_ff);
  assign low_power = (mode_ff >= pmc_pkg::PMC_M_DSLEEP) && (mode_ff <= pmc_pkg::PMC_M_SIDLE);
  assign auto_idle = auto_idle_en_i && (idle_cnt_ff == pmc_pkg::IDLE_AUTO_CYC);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rio_prev_ff <= '0;
    end else begin
      rio_prev_ff <= rio_s;
    end
  end

  // inactivity counter for automatic system idle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      idle_cnt_ff <= 16'h0000;
    end else if (activity_s || mode_ff != pmc_pkg::PMC_M_RUN || req_i) begin
      idle_cnt_ff <= 16'h0000;
    end else if (idle_cnt_ff != pmc_pkg::IDLE_AUTO_CYC) begin
      idle_cnt_ff <= idle_cnt_ff + 16'h0001;
    end
  end

  // mode moves; exits pass rails then clocks stages before run
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      mode_ff <= pmc_pkg::PMC_M_OFF;
      seq_ff <= pmc_pkg::PMC_S_STEADY;
      cnt_ff <= 16'h0000;
      peri_keep_ff <= pmc_pkg::PERI_CLK_RST;
    end else begin
      case (seq_ff)
        pmc_pkg::PMC_S_STEADY: begin
          if (mode_ff == pmc_pkg::PMC_M_RUN && req_i &&
              req_mode_i != pmc_pkg::PMC_M_RUN) begin
            mode_ff <= req_mode_i;
            peri_keep_ff <= peri_keep_i;
          end else if (mode_ff == pmc_pkg::PMC_M_RUN && auto_idle) begin
            mode_ff <= pmc_pkg::PMC_M_SIDLE;
            peri_keep_ff <= peri_keep_i;
          end else if (((mode_ff == pmc_pkg::PMC_M_OFF || mode_ff == pmc_pkg::PMC_M_BATT) &&
                        req_i) || (mode_ff == pmc_pkg::PMC_M_RET && (wake_s || rio_event))) begin
            // full power-up from cold follows the same path as a retention wake
            seq_ff <= pmc_pkg::PMC_S_RAILS;
            cnt_ff <= pmc_pkg::EXIT_RET_CYC;
          end else if (low_power && (wake_s || req_i)) begin
            seq_ff <= pmc_pkg::PMC_S_RAILS;
            // deeper modes wait longer for rails and plls
            if (mode_ff == pmc_pkg::PMC_M_DSLEEP) begin
              cnt_ff <= pmc_pkg::EXIT_DSLEEP_CYC;
            end else if (mode_ff == pmc_pkg::PMC_M_LPIDLE) begin
              cnt_ff <= pmc_pkg::EXIT_LPIDLE_CYC;
            end else begin
              cnt_ff <= pmc_pkg::EXIT_SIDLE_CYC;
            end
          end
        end
        pmc_pkg::PMC_S_RAILS: begin
          if (cnt_ff <= 16'h0001) begin
            seq_ff <= pmc_pkg::PMC_S_CLOCKS;
            cnt_ff <= pmc_pkg::CLK_STEP_CYC;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        pmc_pkg::PMC_S_CLOCKS: begin
          if (cnt_ff <= 16'h0001) begin
            seq_ff <= pmc_pkg::PMC_S_STEADY;
            mode_ff <= pmc_pkg::PMC_M_RUN;
            cnt_ff <= 16'h0000;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        default: seq_ff <= pmc_pkg::PMC_S_STEADY;
      endcase
    end
  end

  // ***************************************************
  // output decode, registered
  // ***************************************************
  logic waking, clk_stage;
  assign waking = (seq_ff != pmc_pkg::PMC_S_STEADY);
  assign clk_stage = (seq_ff == pmc_pkg::PMC_S_CLOCKS);

  // rails: during a wake every run rail except phy comes up first
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      vbat_en_o <= 1'b0;
      vin_en_o <= 1'b0;
      ret_io_en_o <= 1'b0;
      dram_rail_en_o <= 1'b0;
      soc_en_o <= 1'b0;
      cpu_en_o <= 1'b0;
      phy_en_o <= 1'b0;
      peripheral_power_enable_o <= 1'b0;
      vcore_low_o <= 1'b0;
    end else begin
      vbat_en_o <= waking || (mode_ff != pmc_pkg::PMC_M_OFF);
      vin_en_o <= waking || (mode_ff >= pmc_pkg::PMC_M_RET);
      ret_io_en_o <= waking || (mode_ff >= pmc_pkg::PMC_M_RET);
      dram_rail_en_o <= waking || low_power || (mode_ff == pmc_pkg::PMC_M_RUN) ||
                        (mode_ff == pmc_pkg::PMC_M_RET && !dram_off_sel_i);
      soc_en_o <= waking || low_power || (mode_ff == pmc_pkg::PMC_M_RUN);
      cpu_en_o <= waking || (mode_ff == pmc_pkg::PMC_M_RUN) ||
                  (mode_ff == pmc_pkg::PMC_M_SIDLE);
      phy_en_o <= (mode_ff == pmc_pkg::PMC_M_RUN) && !waking && phy_en_i;
      peripheral_power_enable_o <= waking || low_power ||
                                   (mode_ff == pmc_pkg::PMC_M_RUN);
      // core voltage may drop only while frequency is already low
      vcore_low_o <= (mode_ff == pmc_pkg::PMC_M_RUN) && !waking &&
                     low_vcore_i && freq_low_i;
    end
  end

  // dram retention pin and self refresh
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      dram_retention_pin_o <= 1'b1;
      dram_self_refresh_o <= 1'b0;
    end else begin
      dram_retention_pin_o <= !(mode_ff == pmc_pkg::PMC_M_RET && !dram_off_sel_i) &&
                              (mode_ff != pmc_pkg::PMC_M_RUN || waking) &&
                              !low_power;
      dram_self_refresh_o <= (low_power && !clk_stage) ||
                             (mode_ff == pmc_pkg::PMC_M_RET && !dram_off_sel_i &&
                              !clk_stage);
    end
  end

  // cpu release only once in run, after the clock stage
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cpu_run_o <= 1'b0;
      cpu_clk_en_o <= 1'b0;
      sys_clk_en_o <= 1'b0;
      slow_clk_en_o <= 1'b0;
      peri_clk_en_o <= pmc_pkg::PERI_CLK_RST;
    end else begin
      cpu_run_o <= (mode_ff == pmc_pkg::PMC_M_RUN) && !waking;
      cpu_clk_en_o <= ((mode_ff == pmc_pkg::PMC_M_RUN) && !waking) ||
                      (mode_ff == pmc_pkg::PMC_M_SIDLE && !wfi_s && !waking);
      sys_clk_en_o <= clk_stage || (mode_ff == pmc_pkg::PMC_M_RUN) ||
                      (mode_ff == pmc_pkg::PMC_M_SIDLE);
      slow_clk_en_o <= clk_stage || (mode_ff == pmc_pkg::PMC_M_RUN) ||
                       (mode_ff == pmc_pkg::PMC_M_SIDLE) ||
                       (mode_ff == pmc_pkg::PMC_M_LPIDLE);
      if (clk_stage || mode_ff == pmc_pkg::PMC_M_RUN) begin
        peri_clk_en_o <= '1;
      end else if (mode_ff == pmc_pkg::PMC_M_SIDLE || mode_ff == pmc_pkg::PMC_M_LPIDLE) begin
        peri_clk_en_o <= peri_keep_ff;
      end else begin
        peri_clk_en_o <= '0;
      end
    end
  end

  // retention outputs frozen outside run; the watchdog pin is driven like the rest
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      retention_io_pins_o <= '0;
    end else if (mode_ff == pmc_pkg::PMC_M_RUN && !waking) begin
      retention_io_pins_o <= ret_out_i;
    end
  end

  // status
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      mode_o <= pmc_pkg::PMC_M_OFF;
      busy_o <= 1'b0;
    end else begin
      mode_o <= mode_ff;
      busy_o <= waking;
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************
  a_off_rails_dead: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    ($past(mode_ff) == pmc_pkg::PMC_M_OFF && $past(seq_ff) == pmc_pkg::PMC_S_STEADY)
    |-> !vbat_en_o && !vin_en_o && !soc_en_o) else $error("rail on in off mode");
  a_batt_only: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    ($past(mode_ff) == pmc_pkg::PMC_M_BATT && $past(seq_ff) == pmc_pkg::PMC_S_STEADY)
    |-> vbat_en_o && !vin_en_o && !dram_rail_en_o) else $error("battery mode rails wrong");
  a_ret_rails: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    ($past(mode_ff) == pmc_pkg::PMC_M_RET && $past(seq_ff) == pmc_pkg::PMC_S_STEADY)
    |-> vin_en_o && ret_io_en_o && !soc_en_o && !cpu_en_o) else $error("retention rails wrong");
  a_peri_power: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    ($past(mode_ff) <= pmc_pkg::PMC_M_RET && $past(seq_ff) == pmc_pkg::PMC_S_STEADY)
    |-> !peripheral_power_enable_o) else $error("peripheral power on too early");
  a_lp_refresh: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (low_power && seq_ff == pmc_pkg::PMC_S_STEADY) |=> dram_self_refresh_o && !cpu_run_o)
    else $error("low power cpu or dram wrong");
  a_ds_clocks: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (mode_ff == pmc_pkg::PMC_M_DSLEEP && seq_ff == pmc_pkg::PMC_S_STEADY)
    |=> !sys_clk_en_o && !slow_clk_en_o && peri_clk_en_o == '0)
    else $error("clock alive in deep sleep");
  a_sidle_fast: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (mode_ff == pmc_pkg::PMC_M_SIDLE && seq_ff == pmc_pkg::PMC_S_STEADY && wake_s)
    |-> ##[130:132] mode_ff == pmc_pkg::PMC_M_RUN) else $error("system idle exit timing wrong");
  a_wake_order: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $rose(cpu_run_o) |-> $past(sys_clk_en_o, 2) && $past(soc_en_o, 2))
    else $error("cpu released before rails and clocks");
  a_vcore_dvfs: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    vcore_low_o |-> $past(freq_low_i)) else $error("core voltage low at high frequency");
endmodule

// ### pmc_supply_model.sv
// Purpose: far-side model of regulators, dram and off-board supplies
// Assumes: enables from the controller are registered levels
// Notes: reports what the far side would be doing, for the bench to compare
`timescale 1ns/100ps
module pmc_supply_model (
  // rail enables
  input wire logic vin_en_i,
  input wire logic dram_rail_en_i,
  input wire logic peri_pwr_i,
  input wire logic phy_en_i,
  // dram control
  input wire logic dram_retention_pin_i,
  input wire logic dram_self_refresh_i,
  // far-side state
  output logic dram_keeps_data_o,
  output logic ext_peri_up_o,
  output logic phy_up_o
);
  // ***************************************************
  // dram: pin low keeps refresh, high drops it
  // ***************************************************
  // data survives only with the rail up, the off pin low, and either a live
  // controller or self-refresh; an unrefreshed array with no controller decays
  assign dram_keeps_data_o = dram_rail_en_i & ~dram_retention_pin_i &
                             (dram_self_refresh_i | peri_pwr_i);
  // ***************************************************
  // supplies simply follow their enables
  // ***************************************************
  assign ext_peri_up_o = peri_pwr_i & vin_en_i;
  assign phy_up_o = phy_en_i & vin_en_i;
endmodule

// ### tb_top.sv
// Purpose: self-checking bench for the power mode controller
// Assumes: inputs driven at the falling edge, no random stimulus
// Notes: exit waits are bounded loops, the long exits included
`timescale 1ns/100ps
module tb_top;
  // ***************************************************
  // signals
  // ***************************************************
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic req_i = 1'b0;
  pmc_pkg::pmc_mode_type req_mode_i = pmc_pkg::PMC_M_RUN;
  logic dram_off_sel_i = 1'b0, phy_en_i = 1'b1, auto_idle_en_i = 1'b0;
  logic low_vcore_i = 1'b0, freq_low_i = 1'b0, activity_i = 1'b1;
  logic wfi_i = 1'b0, wake_i = 1'b0;
  logic [15:0] rpin_i = 16'h0000, ret_out_i = 16'h5a3c, rpin_o;
  logic [7:0] peri_keep_i = 8'h81, peri_clk_en_o;
  logic vbat, vin, rio, drail, soc, cpu, phy, peri, vlow, dpin, dsr;
  logic crun, cclk, sclk, slclk, busy_o, keeps, eup, pup;
  pmc_pkg::pmc_mode_type mode_o;
  int fail_count = 0, checks_done = 0, n, t_ds, t_lp, t_si;
  pmc_power_mode_controller u_pmc_power_mode_controller (.sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i), .req_i(req_i), .req_mode_i(req_mode_i),
    .dram_off_sel_i(dram_off_sel_i), .phy_en_i(phy_en_i), .peri_keep_i(peri_keep_i),
    .auto_idle_en_i(auto_idle_en_i), .low_vcore_i(low_vcore_i), .freq_low_i(freq_low_i),
    .activity_i(activity_i), .wait_for_interrupt_state_i(wfi_i), .wake_i(wake_i),
    .retention_io_pins_i(rpin_i), .ret_out_i(ret_out_i), .vbat_en_o(vbat), .vin_en_o(vin),
    .ret_io_en_o(rio), .dram_rail_en_o(drail), .soc_en_o(soc), .cpu_en_o(cpu),
    .phy_en_o(phy), .peripheral_power_enable_o(peri), .vcore_low_o(vlow),
    .dram_retention_pin_o(dpin), .dram_self_refresh_o(dsr), .cpu_run_o(crun),
    .cpu_clk_en_o(cclk), .sys_clk_en_o(sclk), .slow_clk_en_o(slclk),
    .peri_clk_en_o(peri_clk_en_o), .retention_io_pins_o(rpin_o), .mode_o(mode_o),
    .busy_o(busy_o));
  pmc_supply_model u_pmc_supply_model (.vin_en_i(vin), .dram_rail_en_i(drail),
    .peri_pwr_i(peri), .phy_en_i(phy), .dram_retention_pin_i(dpin),
    .dram_self_refresh_i(dsr), .dram_keeps_data_o(keeps), .ext_peri_up_o(eup),
    .phy_up_o(pup));
  // ***************************************************
  // clock and helpers
  // ***************************************************
  // 125 MHz
  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  task automatic tick(int k);
    repeat (k) @(negedge sys_clk_i);
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one-cycle request pulse, then let the outputs settle
  task automatic go(pmc_pkg::pmc_mode_type m);
    req_mode_i = m;
    req_i = 1'b1;
    tick(1);
    req_i = 1'b0;
    tick(4);
  endtask
  // bounded wait for run; cpu must stay halted while waking
  task automatic wait_run(output int cyc);
    cyc = 0;
    while (crun !== 1'b1 && cyc < 12000) begin
      if (busy_o === 1'b1 && cyc % 500 == 3) chk("cpu held in wake", {crun, cclk}, 0);
      tick(1);
      cyc++;
    end
    if (cyc >= 12000) begin
      fail_count++;
      print_verdict();
    end
    chk("run rails", {vin, soc, cpu, drail, sclk, busy_o}, 6'h3e);
  endtask
  task automatic wake_up(output int cyc);
    wake_i = 1'b1;
    wait_run(cyc);
    wake_i = 1'b0;
    tick(4);
  endtask
  // ***************************************************
  // scenarios
  // ***************************************************
  initial begin
    tick(6);
    rst_b_i = 1'b1;
    tick(1);
    chk("off rails", {vbat, vin, soc, cpu, drail, peri, rio}, 7'h00);
    go(pmc_pkg::PMC_M_RUN);
    wait_run(n);
    chk("run all", {vbat, vin, rio, peri, phy, crun, eup, pup}, 8'hff);
    phy_en_i = 1'b0;
    low_vcore_i = 1'b1;
    tick(4);
    chk("phy off", {phy, pup}, 2'b00);
    chk("vcore before freq", vlow, 0);
    freq_low_i = 1'b1;
    tick(4);
    chk("vcore after freq", vlow, 1);
    // deep sleep: cpu and clocks gated, dram in self-refresh
    go(pmc_pkg::PMC_M_DSLEEP);
    chk("dsleep", {crun, cpu, sclk, dsr, peri, keeps}, 6'h07);
    wake_up(t_ds);
    go(pmc_pkg::PMC_M_LPIDLE);
    chk("lpidle", {crun, cpu, slclk, dsr, peri}, 5'h07);
    chk("lpidle keep set", peri_clk_en_o, 8'h81);
    wake_up(t_lp);
    go(pmc_pkg::PMC_M_SIDLE);
    chk("sidle", {crun, sclk, dsr, peri}, 4'h7);
    chk("sidle keep set", peri_clk_en_o, 8'h81);
    peri_keep_i = 8'h18;
    wfi_i = 1'b1;
    tick(5);
    chk("wfi gates cpu", cclk, 0);
    chk("keep set latched", peri_clk_en_o, 8'h81);
    wfi_i = 1'b0;
    tick(5);
    chk("cpu clock back", cclk, 1);
    wake_up(t_si);
    chk("exit order", {t_ds > t_lp, t_lp > t_si}, 2'b11);
    // retention with dram in self-refresh
    go(pmc_pkg::PMC_M_RET);
    ret_out_i = 16'h0ff0;
    tick(4);
    chk("ret rails", {vbat, vin, rio, soc, cpu, peri, crun}, 7'h70);
    chk("ret pins held", rpin_o, 16'h5a3c);
    chk("ret dram", {dpin, keeps}, 2'b01);
    rpin_i[3] = 1'b1;
    wait_run(n);
    tick(4);
    chk("ret pins follow", rpin_o, 16'h0ff0);
    dram_off_sel_i = 1'b1;
    go(pmc_pkg::PMC_M_RET);
    chk("ret dram off", {dpin, drail, keeps}, 3'b100);
    rpin_i[3] = 1'b0;
    wait_run(n);
    tick(4);
    // auto system idle after quiet time
    activity_i = 1'b0;
    auto_idle_en_i = 1'b1;
    n = 0;
    while (mode_o !== pmc_pkg::PMC_M_SIDLE && n < 600) begin
      tick(1);
      n++;
    end
    chk("auto idle wait", n >= 256 && n < 600, 1);
    activity_i = 1'b1;
    auto_idle_en_i = 1'b0;
    wake_up(n);
    go(pmc_pkg::PMC_M_BATT);
    chk("batt rails", {vbat, vin, rio, soc, drail, peri}, 6'h20);
    go(pmc_pkg::PMC_M_RUN);
    wait_run(n);
    go(pmc_pkg::PMC_M_OFF);
    chk("off again", {vbat, vin, rio, soc, drail, peri, eup}, 7'h00);
    print_verdict();
  end
endmodule
